//--- core/abc_unit.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - The standard encoding is recognised by major opcode 000001, sub-opcode 00111 and bit 15 clear.
// - The compressed encoding is recognised by major opcode 001000 and sub-opcode 1011 in bits 15:12.
// - The address is the base register plus the sign-extended 12-bit offset.
// - One byte is read, the chosen bit forced to zero, and the byte written back to the same address.
// - The interrupt enable is saved and cleared before the read and restored after the write completes.
// - When the disable input is high the instruction raises a reserved-instruction exception and no access.
// - Both accesses carry a lock flag that the interconnect is expected to honour.
// - Faults of either access, breakpoint, watch and protection included, end the sequence as exceptions.
// - Translation refill, invalid, modified and address errors are reported on the exception port.
// - Translation is requested as a data store and its address and attribute serve both accesses.
// - The byte lane comes from the low address bits with endian adjustment and the store uses the same lane.
// - An armed data-value breakpoint raises its exception before the read is issued.
module abc_unit
  import abc_pkg::*;
#(
  parameter bit USE_LOCK = 1'b1
)
(
  input  wire logic                 clock,
  input  wire logic                 resetn,
  input  wire logic                 clk_en,
  input  wire logic                 issue_valid,
  input  wire logic [31:0]          issue_instr,
  input  wire logic                 issue_compressed,
  input  wire logic                 instr_disable,
  output logic [ABC_REG_W-1:0]      gpr_sel,
  input  wire logic [31:0]          gpr_data,
  input  wire logic                 big_endian_flag,
  input  wire logic                 user_endian_swap_flag,
  input  wire logic                 dbrk_value_armed,
  output logic                      xlat_req,
  output logic [31:0]               xlat_vaddr,
  output logic                      xlat_store,
  input  wire logic                 xlat_done,
  input  wire logic [31:0]          xlat_paddr,
  input  wire logic [2:0]           xlat_cca,
  input  wire logic                 xlat_fault,
  input  wire abc_exc_t             xlat_exc,
  input  wire logic                 global_interrupt_enable_bit,
  output logic                      ie_write,
  output logic                      ie_value,
  output logic                      mem_req,
  output logic                      mem_we,
  output logic [31:0]               mem_addr,
  output logic [3:0]                mem_be,
  output logic [31:0]               mem_wdata,
  output logic [2:0]                mem_cca,
  output logic                      mem_lock,
  input  wire logic                 mem_ack,
  input  wire logic [31:0]          mem_rdata,
  input  wire logic                 mem_err,
  input  wire abc_exc_t             mem_exc,
  output logic                      busy,
  output logic                      done,
  output logic                      exc_valid,
  output abc_exc_t                  exc_code
);
  typedef enum logic [2:0] {ABC_IDLE, ABC_XLAT, ABC_READ, ABC_WRITE, ABC_FINISH} abc_state_t;

  abc_state_t            state_reg;
  logic                  dec_hit;
  logic [ABC_REG_W-1:0]  dec_base;
  logic [ABC_BIT_W-1:0]  dec_bit;
  logic [ABC_OFS_W-1:0]  dec_ofs;
  logic [ABC_BIT_W-1:0]  bit_reg;
  logic [1:0]            lane_reg;
  logic [7:0]            byte_reg;
  logic                  saved_interrupt_enable;
  logic                  start;
  logic                  dis_meta_reg, dis_sync_reg;

  // Lane index in bytes after endian adjustment
  function automatic logic [1:0] abc_lane(input logic [1:0] a, input logic be);
    abc_lane = a ^ {be, be};
  endfunction : abc_lane

  abc_decode u_decode
  (
    .instr      (issue_instr),
    .compressed (issue_compressed),
    .hit        (dec_hit),
    .base_sel   (dec_base),
    .bit_num    (dec_bit),
    .offset     (dec_ofs)
  );

  assign gpr_sel = dec_base;
  assign start   = clk_en && issue_valid && dec_hit && (state_reg == ABC_IDLE);
  assign busy    = (state_reg != ABC_IDLE);

  // Main sequence
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      state_reg  <= ABC_IDLE;
      xlat_req   <= 1'b0;
      xlat_vaddr <= '0;
      xlat_store <= 1'b0;
      mem_req    <= 1'b0;
      mem_we     <= 1'b0;
      mem_addr   <= '0;
      mem_be     <= '0;
      mem_wdata  <= '0;
      mem_cca    <= '0;
      mem_lock   <= 1'b0;
      bit_reg    <= '0;
      lane_reg   <= '0;
      byte_reg   <= '0;
      done       <= 1'b0;
      exc_valid  <= 1'b0;
      exc_code   <= ABC_EXC_NONE;
    end
    else if (clk_en)
    begin
      done      <= 1'b0;
      exc_valid <= 1'b0;
      case (state_reg)
        ABC_IDLE:
        begin
          if (start)
          begin
            if (dis_sync_reg)
            begin
              exc_valid <= 1'b1;
              exc_code  <= ABC_EXC_RESERVED;
            end
            else
            begin
              xlat_vaddr <= gpr_data + {{(32-ABC_OFS_W){dec_ofs[ABC_OFS_W-1]}}, dec_ofs};
              xlat_store <= 1'b1;
              xlat_req   <= 1'b1;
              bit_reg    <= dec_bit;
              state_reg  <= ABC_XLAT;
            end
          end
        end
        ABC_XLAT:
        begin
          if (xlat_done)
          begin
            xlat_req <= 1'b0;
            if (xlat_fault)
            begin
              exc_valid <= 1'b1;
              exc_code  <= xlat_exc;
              state_reg <= ABC_FINISH;
            end
            else if (dbrk_value_armed)
            begin
              exc_valid <= 1'b1;
              exc_code  <= ABC_EXC_BREAKPOINT;
              state_reg <= ABC_FINISH;
            end
            else
            begin
              // Physical address low bits adjusted by the user swap flag
              mem_addr  <= {xlat_paddr[31:2], abc_lane(xlat_paddr[1:0], user_endian_swap_flag)};
              mem_cca   <= xlat_cca;
              lane_reg  <= abc_lane(xlat_vaddr[1:0], big_endian_flag);
              mem_be    <= 4'h1 << abc_lane(xlat_vaddr[1:0], big_endian_flag);
              mem_we    <= 1'b0;
              mem_req   <= 1'b1;
              mem_lock  <= USE_LOCK;
              state_reg <= ABC_READ;
            end
          end
        end
        ABC_READ:
        begin
          if (mem_ack)
          begin
            if (mem_err)
            begin
              mem_req   <= 1'b0;
              mem_lock  <= 1'b0;
              exc_valid <= 1'b1;
              exc_code  <= mem_exc;
              state_reg <= ABC_FINISH;
            end
            else
            begin
              // Clear the chosen bit and place it back in the same lane
              byte_reg  <= mem_rdata[{lane_reg, ABC_BYTE_SHIFT'(0)} +: 8] & (ABC_BYTE_ALL ^ (ABC_BYTE_ONE << bit_reg));
              mem_wdata <= {24'h000000, (mem_rdata[{lane_reg, 3'h0} +: 8] &
                           (ABC_BYTE_ALL ^ (ABC_BYTE_ONE << bit_reg)))} << {lane_reg, 3'h0};
              mem_we    <= 1'b1;
              state_reg <= ABC_WRITE;
            end
          end
        end
        ABC_WRITE:
        begin
          if (mem_ack)
          begin
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            mem_lock  <= 1'b0;
            if (mem_err)
            begin
              exc_valid <= 1'b1;
              exc_code  <= mem_exc;
            end
            else
            begin
              done <= 1'b1;
            end
            state_reg <= ABC_FINISH;
          end
        end
        ABC_FINISH:
        begin
          state_reg <= ABC_IDLE;
        end
        default:
        begin
          state_reg <= ABC_IDLE;
        end
      endcase
    end
  end

  // Disable pin synchroniser, then interrupt enable save, hold off and restore
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      saved_interrupt_enable <= 1'b0;
      ie_write               <= 1'b0;
      ie_value               <= 1'b0;
      dis_meta_reg           <= 1'b0;
      dis_sync_reg           <= 1'b0;
    end
    else if (clk_en)
    begin
      dis_meta_reg <= instr_disable; // Pin from outside the core clock
      dis_sync_reg <= dis_meta_reg;
      ie_write <= 1'b0;
      if (start && !dis_sync_reg)
      begin
        saved_interrupt_enable <= global_interrupt_enable_bit;
        ie_write               <= 1'b1;
        ie_value               <= 1'b0;
      end
      else if (state_reg == ABC_FINISH)
      begin
        ie_write <= 1'b1;
        ie_value <= saved_interrupt_enable;
      end
    end
  end

  // Write only ever follows a good read
  a_no_write_after_fault: assert property (@(posedge clock) disable iff (!resetn)
    (clk_en && state_reg == ABC_READ && mem_ack && mem_err) |=> !mem_req)
    else $error("write issued after faulted read");

  a_disable_raises_ri: assert property (@(posedge clock) disable iff (!resetn)
    (start && dis_sync_reg) |=> (exc_valid && exc_code == ABC_EXC_RESERVED && state_reg == ABC_IDLE))
    else $error("disabled instruction not trapped");

  a_ie_cleared_first: assert property (@(posedge clock) disable iff (!resetn)
    (start && !dis_sync_reg) |=> (ie_write && !ie_value))
    else $error("interrupt enable not cleared");

  a_ie_restored: assert property (@(posedge clock) disable iff (!resetn)
    (clk_en && state_reg == ABC_FINISH) |=> (ie_write && ie_value == $past(saved_interrupt_enable)))
    else $error("interrupt enable not restored");

  a_store_xlat: assert property (@(posedge clock) disable iff (!resetn)
    xlat_req |-> xlat_store)
    else $error("translation not a store");

  a_break_before_read: assert property (@(posedge clock) disable iff (!resetn)
    (clk_en && state_reg == ABC_XLAT && xlat_done && !xlat_fault && dbrk_value_armed)
      |=> (!mem_req && exc_valid && exc_code == ABC_EXC_BREAKPOINT))
    else $error("breakpoint not before read");

  a_single_lane: assert property (@(posedge clock) disable iff (!resetn)
    mem_req |-> $onehot(mem_be))
    else $error("byte enable not one lane");

  a_write_clears_bit: assert property (@(posedge clock) disable iff (!resetn)
    (mem_req && mem_we) |-> !byte_reg[bit_reg])
    else $error("selected bit not cleared");

  a_lock_held: assert property (@(posedge clock) disable iff (!resetn)
    (mem_req && USE_LOCK) |-> mem_lock)
    else $error("lock dropped mid sequence");

  a_xlat_fault_exc: assert property (@(posedge clock) disable iff (!resetn)
    (clk_en && state_reg == ABC_XLAT && xlat_done && xlat_fault) |=> (exc_valid && !mem_req))
    else $error("translation fault lost");
endmodule : abc_unit
`default_nettype wire

//--- core/abc_pkg.sv
package abc_pkg;
  localparam logic [5:0] ABC_STD_MAJOR    = 6'h01; // register_immediate_major_opcode
  localparam logic [4:0] ABC_STD_SUBOP    = 5'h07;
  localparam logic [5:0] ABC_CMP_MAJOR    = 6'h08; // compressed_major_opcode_group
  localparam logic [3:0] ABC_CMP_SUBOP    = 4'hb;
  localparam int         ABC_OFS_W        = 12;
  localparam int         ABC_BIT_W        = 3;
  localparam int         ABC_REG_W        = 5;
  localparam logic [7:0] ABC_BYTE_ALL     = 8'hff;
  localparam logic [7:0] ABC_BYTE_ONE     = 8'h01;
  localparam int         ABC_BYTE_SHIFT   = 3;

  typedef enum logic [2:0]
  {
    ABC_EXC_NONE,
    ABC_EXC_RESERVED,
    ABC_EXC_TLB_REFILL,
    ABC_EXC_TLB_INVALID,
    ABC_EXC_TLB_MODIFIED,
    ABC_EXC_ADDR_ERROR,
    ABC_EXC_BREAKPOINT,
    ABC_EXC_BUS
  } abc_exc_t;
endpackage : abc_pkg

//--- core/abc_decode.sv
`timescale 1ns/1ps
`default_nettype none
module abc_decode
  import abc_pkg::*;
(
  input  wire logic [31:0]          instr,
  input  wire logic                 compressed,
  output logic                      hit,
  output logic [ABC_REG_W-1:0]      base_sel,
  output logic [ABC_BIT_W-1:0]      bit_num,
  output logic [ABC_OFS_W-1:0]      offset
);
  // Field extraction for both encodings
  always_comb
  begin
    if (compressed)
    begin
      hit      = (instr[31:26] == ABC_CMP_MAJOR) && (instr[15:12] == ABC_CMP_SUBOP);
      bit_num  = instr[23:21];
      base_sel = instr[20:16];
    end
    else
    begin
      hit      = (instr[31:26] == ABC_STD_MAJOR) && (instr[20:16] == ABC_STD_SUBOP) && !instr[15];
      bit_num  = instr[14:12];
      base_sel = instr[25:21];
    end
    offset = instr[11:0];
  end
endmodule : abc_decode
`default_nettype wire

//--- testbench/abc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Memory side: every read returns RD_WORD, answers after dly idle cycles
// Distinct bytes per lane, so a wrong lane pick shows in the written byte
module abc_mem_model
#(
  parameter logic [31:0] RD_WORD = 32'hffffffff
)
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic [3:0]  dly,
  input  wire logic        err_rd,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata,
  output logic             mem_err
);
  logic [3:0] cnt_reg;

  // One ack per access; the cycle after an ack is skipped so the
  // write phase is seen before counting starts again
  // Single master, so a locked pair is never split by other traffic
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      mem_ack   <= 1'b0;
      mem_err   <= 1'b0;
      mem_rdata <= 32'h0;
      cnt_reg   <= 4'h0;
    end
    else
    begin
      mem_ack   <= 1'b0;
      mem_err   <= 1'b0;
      mem_rdata <= ~mem_rdata; // Read data is garbage outside the ack
      if (mem_ack)
        cnt_reg <= 4'h0;
      else if (mem_req && cnt_reg >= dly)
      begin
        mem_ack   <= 1'b1;
        mem_err   <= err_rd & ~mem_we;
        mem_rdata <= RD_WORD;
      end
      else if (mem_req)
        cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule : abc_mem_model
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import abc_pkg::*;
  logic        clock, resetn, issue_valid, issue_compressed, instr_disable, big_endian_flag;
  logic        user_endian_swap_flag, dbrk_value_armed, gie, xlat_fault, xlat_done, err_rd;
  logic        xlat_req, xlat_store, ie_write, ie_value, mem_req, mem_we, mem_lock, mem_ack;
  logic        mem_err, busy, done, exc_valid, st_seen, got_done, got_exc;
  logic [31:0] issue_instr, xlat_paddr, xlat_vaddr, mem_addr, mem_wdata, mem_rdata, gpr_data;
  logic [31:0] va_seen, ra, wa, wd;
  logic        clk_en;
  localparam logic [31:0] RD_WORD = 32'h7ebddbe7; // Every lane a different byte
  logic [4:0]  gpr_sel;
  logic [3:0]  mem_be, dly, rbe, wbe;
  logic [2:0]  mem_cca;
  logic [1:0]  ie_log;
  abc_exc_t    xlat_exc, exc_code, got_code;
  int          err_total, tests_run, cycles, nrd, nwr, nie, nbad;

  assign gpr_data = 32'h00004000 + {22'h0, gpr_sel, 5'h00};

  abc_unit u_dut (.clock(clock), .resetn(resetn), .clk_en(clk_en), .issue_valid(issue_valid),
    .issue_instr(issue_instr), .issue_compressed(issue_compressed), .instr_disable(instr_disable),
    .gpr_sel(gpr_sel), .gpr_data(gpr_data), .big_endian_flag(big_endian_flag),
    .user_endian_swap_flag(user_endian_swap_flag), .dbrk_value_armed(dbrk_value_armed),
    .xlat_req(xlat_req), .xlat_vaddr(xlat_vaddr), .xlat_store(xlat_store), .xlat_done(xlat_done),
    .xlat_paddr(xlat_paddr), .xlat_cca(3'h5), .xlat_fault(xlat_fault), .xlat_exc(xlat_exc),
    .global_interrupt_enable_bit(gie), .ie_write(ie_write), .ie_value(ie_value), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_cca(mem_cca),
    .mem_lock(mem_lock), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_err(mem_err),
    .mem_exc(ABC_EXC_BUS), .busy(busy), .done(done), .exc_valid(exc_valid), .exc_code(exc_code));

  abc_mem_model #(.RD_WORD(RD_WORD)) u_mem (.clock(clock), .resetn(resetn), .dly(dly), .err_rd(err_rd),
    .mem_req(mem_req), .mem_we(mem_we), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_err(mem_err));

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Translation answers one cycle after a request; top bit flipped
  always @(posedge clock)
  begin
    xlat_done <= !xlat_done && xlat_req === 1'b1 && resetn;
    xlat_paddr <= xlat_vaddr ^ 32'h80000000;
  end

  // Watch the ports and cut a hang short
  always @(posedge clock)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      err_total++;
      end_of_test();
    end
    if (xlat_req === 1'b1)
    begin
      va_seen = xlat_vaddr;
      st_seen = xlat_store;
    end
    if (mem_req === 1'b1 && (mem_lock !== 1'b1 || mem_cca !== 3'h5)) nbad++;
    if (mem_req === 1'b1 && mem_ack && mem_we === 1'b1)
    begin
      nwr++;
      wa = mem_addr;
      wbe = mem_be;
      wd = mem_wdata;
    end
    if (mem_req === 1'b1 && mem_ack && mem_we === 1'b0)
    begin
      nrd++;
      ra = mem_addr;
      rbe = mem_be;
    end
    if (ie_write === 1'b1)
    begin
      nie++;
      ie_log = {ie_log[0], ie_value};
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    if (err_total == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  function automatic logic [31:0] op(logic c, logic [4:0] b, logic [2:0] t, logic [11:0] o);
    return c ? {ABC_CMP_MAJOR, 2'b00, t, b, ABC_CMP_SUBOP, o} : {ABC_STD_MAJOR, b, ABC_STD_SUBOP, 1'b0, t, o};
  endfunction : op

  // Offer one instruction for one cycle, wait for its end, let restore land;
  // it is always a lone instruction, never one sitting behind a branch
  task automatic run_op(input logic [31:0] instr, input logic cmp);
    int n;
    @(negedge clock);
    nrd = 0;
    nwr = 0;
    nie = 0;
    nbad = 0;
    issue_instr = instr;
    issue_compressed = cmp;
    issue_valid = 1'b1;
    @(negedge clock);
    issue_valid = 1'b0;
    for (n = 0; n < 100 && done !== 1'b1 && exc_valid !== 1'b1; n++) @(negedge clock);
    got_done = done;
    got_exc = exc_valid;
    got_code = exc_code;
    for (n = 0; n < 100 && busy !== 1'b0; n++) @(negedge clock);
    repeat (2) @(negedge clock);
  endtask : run_op

  task automatic good_op(input logic c, input logic [4:0] b, input logic [2:0] t, input logic [11:0] o);
    logic [31:0] va;
    logic [31:0] pa;
    logic [1:0]  ln;
    va = 32'h00004000 + {22'h0, b, 5'h00} + {{20{o[11]}}, o};
    pa = va ^ 32'h80000000;
    ln = va[1:0] ^ {2{big_endian_flag}};
    run_op(op(c, b, t, o), c);
    chk(got_done, 1);
    chk(va_seen, va);
    chk(st_seen, 1);
    chk(nrd * 16 + nwr, 17);
    chk(ra, {pa[31:2], pa[1:0] ^ {2{user_endian_swap_flag}}});
    chk(wa, ra);
    chk({rbe, wbe}, {2{4'h1 << ln}});
    chk(wd, {24'h0, RD_WORD[8 * ln +: 8] & ~(8'h01 << t)} << (8 * ln));
    chk(nbad, 0);
    chk({nie[1:0], ie_log}, {2'd2, 1'b0, gie});
  endtask : good_op

  task automatic bad_op(input logic c, input abc_exc_t code, input int rd);
    run_op(op(c, 5'd3, 3'd5, 12'h004), c);
    chk({got_exc, got_code}, {1'b1, code});
    chk(nrd * 16 + nwr, rd * 16);
  endtask : bad_op

  task automatic t_std_bits();
    for (int i = 0; i < 8; i++)
    begin
      dly = 4'(i);
      gie = i[0];
      good_op(1'b0, 5'(i * 3 + 1), 3'(i), (i == 7) ? 12'h7ff : 12'(i * 37));
    end
  endtask : t_std_bits

  task automatic t_cmp_endian();
    for (int i = 0; i < 4; i++)
    begin
      @(negedge clock);
      {big_endian_flag, user_endian_swap_flag} = i[1:0];
      good_op(1'b1, 5'(31 - i), 3'(7 - i), 12'(2048 + i * 5));
    end
  endtask : t_cmp_endian

  task automatic t_faults();
    @(negedge clock);
    instr_disable = 1'b1;
    repeat (2) @(negedge clock); // Pin passes a two-stage synchroniser
    bad_op(1'b0, ABC_EXC_RESERVED, 0);
    bad_op(1'b1, ABC_EXC_RESERVED, 0);
    instr_disable = 1'b0;
    repeat (2) @(negedge clock);
    xlat_fault = 1'b1;
    for (int i = 2; i < 6; i++)
    begin
      xlat_exc = abc_exc_t'(i);
      bad_op(i[0], abc_exc_t'(i), 0);
    end
    xlat_fault = 1'b0;
    dbrk_value_armed = 1'b1;
    bad_op(1'b0, ABC_EXC_BREAKPOINT, 0);
    dbrk_value_armed = 1'b0;
    err_rd = 1'b1;
    bad_op(1'b1, ABC_EXC_BUS, 1);
    chk(mem_lock, 0);
    err_rd = 1'b0;
  endtask : t_faults

  task automatic t_ignored();
    run_op(op(1'b0, 5'd2, 3'd1, 12'h010) | 32'h00008000, 1'b0);
    chk({got_done, got_exc, nrd[0]}, 0);
    run_op(op(1'b1, 5'd2, 3'd1, 12'h010) ^ 32'h00001000, 1'b1);
    chk({got_done, got_exc, nrd[0]}, 0);
  endtask : t_ignored

  // Clock enable low mid-sequence: nothing may advance, then the op completes
  task automatic t_freeze();
    int n;
    logic [1:0] ln;
    ln = 2'h2 ^ {2{big_endian_flag}};
    @(negedge clock);
    issue_instr = op(1'b1, 5'd7, 3'd3, 12'h006);
    issue_compressed = 1'b1;
    issue_valid = 1'b1;
    @(negedge clock);
    issue_valid = 1'b0;
    clk_en = 1'b0;
    repeat (6) @(negedge clock);
    chk({busy, xlat_req, mem_req, done}, 4'hc);
    clk_en = 1'b1;
    for (n = 0; n < 100 && done !== 1'b1; n++) @(negedge clock);
    chk(done, 1);
    for (n = 0; n < 100 && busy !== 1'b0; n++) @(negedge clock);
    repeat (2) @(negedge clock);
    chk(wd, {24'h0, RD_WORD[8 * ln +: 8] & ~(8'h01 << 3)} << (8 * ln));
  endtask : t_freeze

  // Reset in the middle of a locked access, then a clean op afterwards
  task automatic t_reset();
    int n;
    @(negedge clock);
    issue_instr = op(1'b0, 5'd9, 3'd6, 12'h020);
    issue_compressed = 1'b0;
    issue_valid = 1'b1;
    @(negedge clock);
    issue_valid = 1'b0;
    for (n = 0; n < 40 && mem_req !== 1'b1; n++) @(negedge clock);
    resetn = 1'b0;
    @(negedge clock);
    chk({busy, mem_req, mem_lock, xlat_req, ie_write, done, exc_valid}, 0);
    chk(exc_code, ABC_EXC_NONE);
    resetn = 1'b1;
    good_op(1'b0, 5'd9, 3'd6, 12'h020);
  endtask : t_reset

  initial
  begin
    {resetn, issue_valid, issue_compressed, instr_disable, big_endian_flag} = 5'h0;
    {user_endian_swap_flag, dbrk_value_armed, xlat_fault, xlat_done, err_rd} = 5'h0;
    gie = 1'b1;
    clk_en = 1'b1;
    issue_instr = 32'h0;
    xlat_exc = ABC_EXC_NONE;
    dly = 4'h0;
    err_total = 0;
    tests_run = 0;
    cycles = 0;
    repeat (8) @(negedge clock);
    resetn = 1'b1;
    t_std_bits();
    t_cmp_endian();
    t_faults();
    t_ignored();
    t_freeze();
    t_reset();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
